// ---- core/csi_pkg.sv ----
package csi_pkg;

  // Port addresses
  localparam logic [7:0] PSC_ADDR = 8'hFF;
  localparam logic [7:0] GIE_ADDR = 8'h20;
  localparam logic [7:0] EPE_ADDR = 8'h21;

  // Processor status and control field positions
  localparam int PSC_RUN = 0;
  localparam int PSC_RSVD = 1;
  localparam int PSC_IE_SENSE = 2;
  localparam int PSC_SUSPEND = 3;
  localparam int PSC_POR = 4;
  localparam int PSC_BUS_RST = 5;
  localparam int PSC_WDOG = 6;
  localparam int PSC_PENDING = 7;
  localparam logic [7:0] PSC_RESET = 8'h11;

  // Global interrupt enable field positions
  localparam int GIE_BUS_RST = 0;
  localparam int GIE_T128 = 1;
  localparam int GIE_T1024 = 2;
  localparam int GIE_HUB = 3;
  localparam int GIE_GPIO = 5;
  localparam int GIE_SERIAL = 6;
  localparam logic [7:0] GIE_WMASK = 8'h6F;
  localparam logic [7:0] GIE_RESET = 8'h00;
  localparam int EPE_W = 5;
  localparam logic [EPE_W-1:0] EPE_RESET = 5'h00;

  // Interrupt sources, highest priority at index 0
  localparam int NSRC = 11;
  localparam int SRC_BUS_RST = 0;
  localparam int SRC_T128 = 1;
  localparam int SRC_T1024 = 2;
  localparam int SRC_EP0 = 3;
  localparam int SRC_HUB = 8;
  localparam int SRC_GPIO = 9;
  localparam int SRC_SERIAL = 10;
  localparam logic [NSRC-1:0] PEND_RESET = 11'h000;

  // Vector number of each source; vector slot 10 has no source here
  localparam logic [3:0] VEC_NUM [NSRC] = '{
    4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC
  };
  localparam int VEC_W = 14;

  // Timing at the 10 MHz core clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SE0_MIN_NS = 12000;
  localparam int SE0_CYC = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_NS = 128000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

endpackage

// ---- core/csi_evt_if.sv ----
`timescale 1ns/100ps
interface csi_evt_if;
  logic bus_reset_det;
  logic tick_128us;

  modport det (output bus_reset_det);
  modport tmr (output tick_128us);
  modport core (input bus_reset_det, input tick_128us);
endinterface

// ---- core/csi_se0_detect.sv ----
`timescale 1ns/100ps
module csi_se0_detect (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic dp_i,
  input wire logic dm_i,
  csi_evt_if.det evt
);
  localparam logic [csi_pkg::CNT_W-1:0] SE0_LAST = csi_pkg::CNT_W'(csi_pkg::SE0_CYC);
  logic [csi_pkg::CNT_W-1:0] cnt_q;
  logic hit_q;

  // Hit needs the full minimum of SE0 samples; the count then parks so a long SE0 reports once
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (dp_i || dm_i) begin
      cnt_q <= '0;
    end else if (cnt_q != SE0_LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= !dp_i && !dm_i && (cnt_q == SE0_LAST - 1'b1);
    end
  end

  assign evt.bus_reset_det = hit_q;
endmodule // csi_se0_detect

// ---- core/csi_tick_timer.sv ----
`timescale 1ns/100ps
module csi_tick_timer (
  input wire logic clock_i,
  input wire logic rst_b_i,
  csi_evt_if.tmr evt
);
  localparam logic [csi_pkg::CNT_W-1:0] TICK_LAST = csi_pkg::CNT_W'(csi_pkg::TICK_CYC - 1);
  logic [csi_pkg::CNT_W-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == TICK_LAST);
      cnt_q <= (cnt_q == TICK_LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign evt.tick_128us = tick_q;
endmodule // csi_tick_timer

// ---- core/csi_core.sv ----
`timescale 1ns/100ps
// Overview of operation
// - Stop clears status, halts until reset
// - Bit 2 reads enable state, ignores writes
// - Mask, unmask, return, service, stop, watchdog change enable
// - Suspend bit write halts into suspend
// - Enabled pending interrupt or activity wakes
// - Suspend write ignored during bus activity
// - Power-on reset sets bit 4
// - Long single-ended zero sets bit 5
// - Watchdog reset sets bit 6
// - Bit 7 shows pending until serviced
// - Power-up status value is 00010001
// - Start-up watchdog reset gives 01010001
// - Watchdog loads 01XX0001, keeps bits 4-5
// - Every source gated by own enable
// - Global enable bit map, reset zero
// - Timer requests every 128 us when enabled
// - Service clears enable, pending, calls vector
// - Any reset clears all enable registers
// - Per-source pending, highest priority first
module csi_core (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic watchdog_reset_event_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic stop_instruction_i,
  input wire logic mask_all_instruction_i,
  input wire logic unmask_all_instruction_i,
  input wire logic return_from_isr_instruction_i,
  input wire logic instr_done_i,
  input wire logic usb_activity_i,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic timer_1024us_i,
  input wire logic [csi_pkg::EPE_W-1:0] endpoint_irq_i,
  input wire logic hub_irq_i,
  input wire logic gpio_irq_i,
  input wire logic serial_irq_i,
  output logic core_halted_o,
  output logic suspend_o,
  output logic irq_take_o,
  output logic [csi_pkg::VEC_W-1:0] irq_vector_o
);

  csi_evt_if evt ();

  csi_se0_detect u_se0 (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .dp_i(dp_i),
    .dm_i(dm_i),
    .evt(evt.det)
  );

  csi_tick_timer u_tick (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .evt(evt.tmr)
  );

  logic run_q;
  logic suspend_q;
  logic por_q;
  logic bus_rst_q;
  logic wdog_q;
  logic ie_q;
  logic [7:0] gie_q;
  logic [csi_pkg::EPE_W-1:0] epe_q;
  logic [csi_pkg::NSRC-1:0] pend_q;
  logic [csi_pkg::NSRC-1:0] src_raw;
  logic [csi_pkg::NSRC-1:0] src_en;
  logic [csi_pkg::NSRC-1:0] req;
  logic [csi_pkg::NSRC-1:0] take_oh;
  logic irq_take_q;
  logic [csi_pkg::VEC_W-1:0] vector_q;
  logic [7:0] rdata_q;
  logic psc_wr;
  logic gie_wr;
  logic epe_wr;
  logic running;
  logic service;
  logic wake;
  logic [csi_pkg::VEC_W-1:0] vector_d;
  logic [7:0] status;
  logic pend_clr;
  logic psc_flag_wr;

  // Lowest set bit wins, matching vector priority
  function automatic logic [csi_pkg::NSRC-1:0] first_one(input logic [csi_pkg::NSRC-1:0] v);
    logic [csi_pkg::NSRC-1:0] r;
    r = '0;
    for (int i = csi_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Port address match, shared by every write decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  assign psc_wr = io_wr_i && addr_hit(io_addr_i, csi_pkg::PSC_ADDR);
  assign gie_wr = io_wr_i && addr_hit(io_addr_i, csi_pkg::GIE_ADDR);
  assign epe_wr = io_wr_i && addr_hit(io_addr_i, csi_pkg::EPE_ADDR);
  // A watchdog cycle keeps the power-on and bus flags, so a racing write is dropped
  assign psc_flag_wr = psc_wr && !watchdog_reset_event_i;
  // Watchdog and stop both wipe the interrupt state in one cycle
  assign pend_clr = watchdog_reset_event_i || stop_instruction_i;
  // Suspend stops fetch without touching the run bit
  assign running = run_q && !suspend_q;

  // Raw source events; the 128 us tick is only raised while enabled
  always_comb begin
    src_raw = '0;
    src_raw[csi_pkg::SRC_BUS_RST] = evt.bus_reset_det;
    src_raw[csi_pkg::SRC_T128] = evt.tick_128us && gie_q[csi_pkg::GIE_T128];
    src_raw[csi_pkg::SRC_T1024] = timer_1024us_i;
    src_raw[csi_pkg::SRC_EP0 +: csi_pkg::EPE_W] = endpoint_irq_i;
    src_raw[csi_pkg::SRC_HUB] = hub_irq_i;
    src_raw[csi_pkg::SRC_GPIO] = gpio_irq_i;
    src_raw[csi_pkg::SRC_SERIAL] = serial_irq_i;
  end

  // Per-source enable mapping
  always_comb begin
    src_en = '0;
    src_en[csi_pkg::SRC_BUS_RST] = gie_q[csi_pkg::GIE_BUS_RST];
    src_en[csi_pkg::SRC_T128] = gie_q[csi_pkg::GIE_T128];
    src_en[csi_pkg::SRC_T1024] = gie_q[csi_pkg::GIE_T1024];
    src_en[csi_pkg::SRC_EP0 +: csi_pkg::EPE_W] = epe_q;
    src_en[csi_pkg::SRC_HUB] = gie_q[csi_pkg::GIE_HUB];
    src_en[csi_pkg::SRC_GPIO] = gie_q[csi_pkg::GIE_GPIO];
    src_en[csi_pkg::SRC_SERIAL] = gie_q[csi_pkg::GIE_SERIAL];
  end

  assign req = pend_q & src_en;
  // Taken only at an instruction boundary with the core enabled
  assign service = running && ie_q && instr_done_i && (|req);
  assign take_oh = service ? first_one(req) : '0;
  // Wake ignores the core enable: an enabled source resumes even while masked
  assign wake = suspend_q && (usb_activity_i || (|req));

  // Select is one-hot, so at most one vector is picked
  always_comb begin
    vector_d = '0;
    for (int i = 0; i < csi_pkg::NSRC; i++) begin
      if (take_oh[i]) begin
        vector_d = {9'h000, csi_pkg::VEC_NUM[i], 1'b0};
      end
    end
  end

  // Pending flip-flops: a new event beats the service clear
  generate
    for (genvar g = 0; g < csi_pkg::NSRC; g++) begin : g_pend
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pend_q[g] <= csi_pkg::PEND_RESET[g];
        end else if (pend_clr) begin
          pend_q[g] <= 1'b0;
        end else if (src_raw[g]) begin
          pend_q[g] <= 1'b1;
        end else if (take_oh[g]) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Core global interrupt enable; service beats unmask, so nesting needs a fresh unmask
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ie_q <= 1'b0;
    end else if (pend_clr) begin
      ie_q <= 1'b0;
    end else if (service) begin
      ie_q <= 1'b0;
    end else if (mask_all_instruction_i) begin
      ie_q <= 1'b0;
    end else if (unmask_all_instruction_i || return_from_isr_instruction_i) begin
      ie_q <= 1'b1;
    end
  end

  // Global enable register, cleared by every reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gie_q <= csi_pkg::GIE_RESET;
    end else if (watchdog_reset_event_i) begin
      gie_q <= csi_pkg::GIE_RESET;
    end else if (gie_wr) begin
      gie_q <= io_wdata_i & csi_pkg::GIE_WMASK;
    end
  end

  // Endpoint enable register, cleared by every reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      epe_q <= csi_pkg::EPE_RESET;
    end else if (watchdog_reset_event_i) begin
      epe_q <= csi_pkg::EPE_RESET;
    end else if (epe_wr) begin
      epe_q <= io_wdata_i[csi_pkg::EPE_W-1:0];
    end
  end

  // Run bit
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= csi_pkg::PSC_RESET[csi_pkg::PSC_RUN];
    end else if (watchdog_reset_event_i) begin
      run_q <= 1'b1;
    end else if (stop_instruction_i) begin
      run_q <= 1'b0;
    end else if (psc_wr) begin
      run_q <= io_wdata_i[csi_pkg::PSC_RUN];
    end
  end

  // Suspend bit; refused while the bus is active
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      suspend_q <= csi_pkg::PSC_RESET[csi_pkg::PSC_SUSPEND];
    end else if (pend_clr) begin
      suspend_q <= 1'b0;
    end else if (wake) begin
      suspend_q <= 1'b0;
    end else if (psc_wr) begin
      suspend_q <= io_wdata_i[csi_pkg::PSC_SUSPEND] && !usb_activity_i;
    end
  end

  // Power-on flag survives a watchdog reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_q <= csi_pkg::PSC_RESET[csi_pkg::PSC_POR];
    end else if (stop_instruction_i) begin
      por_q <= 1'b0;
    end else if (psc_flag_wr) begin
      por_q <= io_wdata_i[csi_pkg::PSC_POR];
    end
  end

  // Bus reset flag; detection wins over a firmware clear
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_rst_q <= csi_pkg::PSC_RESET[csi_pkg::PSC_BUS_RST];
    end else if (evt.bus_reset_det) begin
      bus_rst_q <= 1'b1;
    end else if (stop_instruction_i) begin
      bus_rst_q <= 1'b0;
    end else if (psc_flag_wr) begin
      bus_rst_q <= io_wdata_i[csi_pkg::PSC_BUS_RST];
    end
  end

  // Watchdog flag; the start-up suspend watchdog lands here too
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_q <= csi_pkg::PSC_RESET[csi_pkg::PSC_WDOG];
    end else if (watchdog_reset_event_i) begin
      wdog_q <= 1'b1;
    end else if (stop_instruction_i) begin
      wdog_q <= 1'b0;
    end else if (psc_wr) begin
      wdog_q <= io_wdata_i[csi_pkg::PSC_WDOG];
    end
  end

  // Service strobe, one cycle after the take edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= service;
    end
  end

  // Vector of the last serviced source, held for the core's call
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vector_q <= '0;
    end else if (service) begin
      vector_q <= vector_d;
    end
  end

  // Status byte built from the field positions; reserved bit 1 stays zero
  always_comb begin
    status = 8'h00;
    status[csi_pkg::PSC_RUN] = run_q;
    status[csi_pkg::PSC_IE_SENSE] = ie_q;
    status[csi_pkg::PSC_SUSPEND] = suspend_q;
    status[csi_pkg::PSC_POR] = por_q;
    status[csi_pkg::PSC_BUS_RST] = bus_rst_q;
    status[csi_pkg::PSC_WDOG] = wdog_q;
    status[csi_pkg::PSC_PENDING] = |pend_q;
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (io_rd_i) begin
      unique case (io_addr_i)
        csi_pkg::PSC_ADDR: begin
          rdata_q <= status;
        end
        csi_pkg::GIE_ADDR: begin
          rdata_q <= gie_q;
        end
        csi_pkg::EPE_ADDR: begin
          rdata_q <= {3'h0, epe_q};
        end
        default: begin
          // Unmapped ports read as zero
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  assign io_rdata_o = rdata_q;
  assign core_halted_o = !running;
  assign suspend_o = suspend_q;
  assign irq_take_o = irq_take_q;
  assign irq_vector_o = vector_q;

endmodule // csi_core

// ---- sim/csi_core_monitor.sv ----
`timescale 1ns/100ps
module csi_core_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic watchdog_reset_event_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic stop_instruction_i,
  input wire logic instr_done_i,
  input wire logic usb_activity_i,
  input wire logic core_halted_o,
  input wire logic suspend_o,
  input wire logic irq_take_o,
  input wire logic [13:0] irq_vector_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  logic susp_wr;
  assign susp_wr = io_wr_i && io_addr_i == csi_pkg::PSC_ADDR && io_wdata_i[3];
  a_take_single: assert property (irq_take_o |=> !irq_take_o)
    else $error("service pulse longer than one cycle");
  a_take_cause: assert property (irq_take_o |-> $past(instr_done_i) || $past(instr_done_i, 2))
    else $error("service without instruction end");
  a_vector_moves: assert property ($changed(irq_vector_o) |-> irq_take_o)
    else $error("vector changed without service");
  a_stop_halts: assert property (stop_instruction_i |-> ##[1:2] core_halted_o)
    else $error("stop did not halt");
  a_susp_refused: assert property (susp_wr && usb_activity_i && !suspend_o |=> !suspend_o)
    else $error("suspend entered during bus activity");
  a_susp_enter: assert property (susp_wr && !usb_activity_i && !watchdog_reset_event_i
      && !stop_instruction_i |=> suspend_o)
    else $error("suspend write not taken");
  a_susp_halts: assert property (suspend_o |-> core_halted_o)
    else $error("suspend without halt");
  a_wake_bus: assert property (suspend_o && usb_activity_i |=> !suspend_o)
    else $error("bus activity did not wake");
  a_wdog_runs: assert property (watchdog_reset_event_i |=> !suspend_o && !core_halted_o)
    else $error("watchdog reset left core stopped");
  a_gie_rsvd: assert property (io_rd_i && io_addr_i == csi_pkg::GIE_ADDR
      |=> io_rdata_o[7] == 1'b0 && io_rdata_o[4] == 1'b0)
    else $error("reserved enable bit read as one");
endmodule // csi_core_monitor
bind csi_core csi_core_monitor i_mon (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .watchdog_reset_event_i(watchdog_reset_event_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .stop_instruction_i(stop_instruction_i), .instr_done_i(instr_done_i),
  .usb_activity_i(usb_activity_i), .core_halted_o(core_halted_o), .suspend_o(suspend_o),
  .irq_take_o(irq_take_o), .irq_vector_o(irq_vector_o));

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic io_wr_i = 1'b0, io_rd_i = 1'b0, act = 1'b0, dp = 1'b1, dm = 1'b0;
  logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o;
  // Event strobes: wdog,stop,mask,unmask,return_from_isr_instruction,done,t1024,hub,gpio,serial
  logic [9:0] ev = 10'h000;
  logic [4:0] ep = 5'h00;
  logic halted, susp, take_o;
  logic [13:0] vec;
  int mismatches = 0, n_tests = 0, cyc = 0;
  csi_core i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .watchdog_reset_event_i(ev[0]),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .stop_instruction_i(ev[1]), .mask_all_instruction_i(ev[2]),
    .unmask_all_instruction_i(ev[3]), .return_from_isr_instruction_i(ev[4]),
    .instr_done_i(ev[5]), .usb_activity_i(act), .dp_i(dp), .dm_i(dm),
    .timer_1024us_i(ev[6]), .endpoint_irq_i(ep), .hub_irq_i(ev[7]), .gpio_irq_i(ev[8]),
    .serial_irq_i(ev[9]), .core_halted_o(halted), .suspend_o(susp), .irq_take_o(take_o),
    .irq_vector_o(vec));
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs move 10 ns after each rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    tick(1);
    // One idle edge keeps back-to-back strobes apart
    io_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    io_addr_i = a;
    io_rd_i = 1'b1;
    tick(1);
    io_rd_i = 1'b0;
    chk(io_rdata_o, exp);
    tick(1);
  endtask
  task automatic pulse(input logic [9:0] m);
    ev = m;
    tick(1);
    ev = 10'h000;
  endtask
  // Ends an instruction and expects one service with the given vector
  task automatic take(input logic [13:0] v);
    int k = 0;
    pulse(10'h020);
    while (take_o !== 1'b1 && k < 3) begin
      tick(1);
      k++;
    end
    chk(take_o, 1'b1);
    chk(vec, v);
    tick(1);
  endtask
  task automatic t_regs();
    rdc(8'hFF, 8'h11);
    rdc(8'h20, 8'h00);
    rdc(8'h21, 8'h00);
    rdc(8'h33, 8'h00);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h6F);
    wr(8'h20, 8'h00);
    wr(8'hFF, 8'h75);
    rdc(8'hFF, 8'h71);
    wr(8'hFF, 8'h01);
    rdc(8'hFF, 8'h01);
    pulse(10'h008);
    wr(8'hFF, 8'h01);
    rdc(8'hFF, 8'h05);
    pulse(10'h004);
    rdc(8'hFF, 8'h01);
    pulse(10'h010);
    rdc(8'hFF, 8'h05);
    pulse(10'h004);
    $display("register test done");
  endtask
  task automatic t_irq();
    logic [13:0] v[4] = '{14'h0006, 14'h0010, 14'h0016, 14'h0018};
    pulse(10'h080);
    rdc(8'hFF, 8'h81);
    wr(8'h20, 8'h08);
    pulse(10'h020);
    chk(take_o, 1'b0);
    pulse(10'h008);
    take(14'h0012);
    rdc(8'hFF, 8'h01);
    wr(8'h20, 8'h64);
    wr(8'h21, 8'h1F);
    ep = 5'h10;
    pulse(10'h340);
    ep = 5'h00;
    // Return re-enables, so the four pending sources drain in priority order
    for (int i = 0; i < 4; i++) begin
      pulse(10'h010);
      take(v[i]);
    end
    rdc(8'hFF, 8'h01);
    wr(8'h21, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_susp();
    act = 1'b1;
    wr(8'hFF, 8'h09);
    chk(susp, 1'b0);
    act = 1'b0;
    wr(8'hFF, 8'h09);
    chk(susp, 1'b1);
    chk(halted, 1'b1);
    act = 1'b1;
    tick(2);
    chk(susp, 1'b0);
    act = 1'b0;
    wr(8'h20, 8'h08);
    wr(8'hFF, 8'h09);
    chk(susp, 1'b1);
    pulse(10'h080);
    tick(2);
    chk(susp, 1'b0);
    pulse(10'h008);
    take(14'h0012);
    $display("suspend test done");
  endtask
  task automatic t_timing();
    wr(8'h20, 8'h01);
    // A K state and a 119-cycle SE0 both fall short of a bus reset
    dp = 1'b0;
    dm = 1'b1;
    tick(125);
    dm = 1'b0;
    tick(119);
    dp = 1'b1;
    tick(3);
    rdc(8'hFF, 8'h01);
    dp = 1'b0;
    tick(120);
    dp = 1'b1;
    tick(3);
    rdc(8'hFF, 8'hA1);
    pulse(10'h010);
    take(14'h0002);
    wr(8'hFF, 8'h01);
    wr(8'h20, 8'h02);
    tick(1300);
    pulse(10'h010);
    take(14'h0004);
    wr(8'h20, 8'h00);
    tick(1300);
    rdc(8'hFF, 8'h01);
    $display("timing test done");
  endtask
  task automatic t_reset();
    wr(8'hFF, 8'h31);
    wr(8'h20, 8'h08);
    pulse(10'h080);
    pulse(10'h001);
    rdc(8'hFF, 8'h71);
    rdc(8'h20, 8'h00);
    wr(8'hFF, 8'h11);
    pulse(10'h001);
    rdc(8'hFF, 8'h51);
    pulse(10'h002);
    rdc(8'hFF, 8'h00);
    tick(5);
    chk(halted, 1'b1);
    pulse(10'h001);
    chk(halted, 1'b0);
    rdc(8'hFF, 8'h41);
    // Second power-on reset in mid-run sets the power-on flag again
    rst_b_i = 1'b0;
    tick(2);
    rst_b_i = 1'b1;
    rdc(8'hFF, 8'h11);
    chk(halted, 1'b0);
    $display("reset test done");
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs about 3100 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 10000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    #10;
    rst_b_i = 1'b1;
    t_regs();
    t_irq();
    t_susp();
    t_timing();
    t_reset();
    end_sim();
  end
endmodule // tb_top
